// *** shared/vss_pkg.sv ***
// Shared constants and types of the Viterbi session sequencer
package vss_pkg;
    localparam int ADDR_W = 32;
    localparam int WORD_W = 64;
    localparam int NUM_STATES = 16;
    localparam int STATE_W = 4;
    localparam int METRIC_W = 16;
    localparam int HIST_WORDS = 8;
    localparam int HIST_W = 3;
    localparam int COUNT_W = 12;
    localparam int FIFO_DEPTH = 8;
    localparam int RTB_SHORT = 16;
    localparam int RTB_LONG = 32;
    localparam int SYMS_PER_WORD = 8;
    localparam int METRICS_PER_WORD = 4;
    localparam logic [ADDR_W-1:0] ADDR_STEP = 32'h0000_0008;
    localparam logic [METRIC_W-1:0] METRIC_CLEAR = 16'h0000;

    typedef enum logic [3:0] {
        VSS_METRIC_WIPE,
        VSS_METRIC_LOAD,
        VSS_FF,
        VSS_FF_TB,
        VSS_WIPE_FF,
        VSS_WIPE_FF_TB,
        VSS_TRACEBACK,
        VSS_HIST_DUMP,
        VSS_ABORT
    } vss_cmd_t;

    typedef struct packed {
        logic ff_done;
        logic tb_done;
        logic hd_done;
        logic pm_done;
        logic abort_done;
    } vss_status_t;

    typedef struct packed {
        logic [1:0] rate;
        logic [3:0] puncture;
        logic [2:0] constraint_len;
        logic equalize;
        logic recursive;
        logic depth32;
        logic min_sel;
        logic max_sel;
        logic pm_init_upper;
        vss_status_t irq_en;
    } vss_cfg_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [WORD_W-1:0] data;
    } vss_wr_t;
endpackage

// *** rtl/vss_fifo.sv ***
// Write-path FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module vss_fifo #(
    parameter int WIDTH = 96,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Fill side
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // Drain side
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int PTR_W = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [PTR_W:0] count;
    wire logic push = in_valid && in_ready;
    wire logic pop = out_valid && out_ready;
    wire logic [PTR_W:0] next_count = count + (PTR_W+1)'(push) - (PTR_W+1)'(pop);

    assign out_data = mem[rd_ptr];

    always_ff @(posedge clk) begin
        if (reset) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            in_ready <= 1'b0;
            out_valid <= 1'b0;
        end else begin
            if (push) begin
                mem[wr_ptr] <= in_data;
                wr_ptr <= (wr_ptr == PTR_W'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == PTR_W'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= next_count;
            in_ready <= next_count != (PTR_W+1)'(DEPTH);
            out_valid <= next_count != '0;
        end
    end
endmodule
`default_nettype wire

// *** rtl/vss_sequencer.sv ***
// Session sequencer: metric wipe/load, feed-forward, traceback, recursive traceback, history dump
//
// Contract
// R1 - Before a session, metrics are wiped or loaded from memory by a load command.
// R2 - Init sets any number of states; auto variant sets one state, one half.
// R3 - Core writes input start address and input block length.
// R4 - Core loads three autocorrelation coefficients before equalization.
// R5 - Equalization writes assist deltas starting at the assist output address.
// R6 - With traceback, results are stored from the traceback output address.
// R7 - Equalization starts as FF, FF then traceback, or wipe-FF-traceback.
// R8 - Recursive traceback roots at each path point, first step inverted.
// R9 - Recursive branches are limited to 16 or 32 stages.
// R10 - Start state by min, max metric selects, or predefined start state.
// R11 - Traceback runs a learning period before emitting decisions.
// R12 - Core programs code polynomials before a decoding session.
// R13 - Session starts on command with its configuration and interrupt enables.
// R14 - Feed-forward is entered only from idle.
// R15 - Abort returns a running session to idle.
// R16 - FF ends at the symbol count, then traceback if chained, else idle.
// R17 - Equalization dumps history automatically unless recursive traceback runs; here an FF-only session with recursive set ends without a dump.
// R18 - Core sets block size and constraint length before explicit dump.
// R19 - Hard traceback packs decisions into 64-bit output words.
// R20 - Core programs traceback parameters while idle.
// R21 - FF with traceback switches automatically.
// R22 - Wipe session proceeds automatically into feed-forward.
// R23 - Triple session chains wipe, feed-forward and traceback from one command.
// R24 - Completion sets status bits and interrupt lines.
// R25 - Non-abort commands while running are ignored.
`timescale 1ns/1ps
`default_nettype none
module vss_sequencer import vss_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Command
    input wire logic cmd_valid,
    input wire vss_cmd_t cmd,
    input wire vss_cfg_t cfg,
    // Session settings
    input wire logic [ADDR_W-1:0] input_start_addr,
    input wire logic [COUNT_W-1:0] input_block_length,
    input wire logic [COUNT_W-1:0] session_symbol_count,
    input wire logic [7:0] autocorr_coeff_a,
    input wire logic [7:0] autocorr_coeff_b,
    input wire logic [7:0] autocorr_coeff_c,
    input wire logic [7:0] code_polynomials,
    input wire logic [ADDR_W-1:0] assist_out_addr,
    input wire logic [ADDR_W-1:0] tb_out_addr,
    input wire logic [ADDR_W-1:0] metric_load_addr,
    input wire logic [4:0] pm_init_count,
    input wire logic [METRIC_W-1:0] pm_init_value,
    input wire logic [STATE_W-1:0] predefined_start_state,
    input wire logic [HIST_W-1:0] learning_period,
    // Status
    input wire vss_status_t status_clear,
    output vss_status_t status,
    output vss_status_t irq,
    output logic busy,
    output logic [STATE_W-1:0] tb_start_state,
    // Memory read
    output logic rd_req_valid,
    output logic [ADDR_W-1:0] rd_req_addr,
    input wire logic rd_req_ready,
    input wire logic rd_data_valid,
    input wire logic [WORD_W-1:0] rd_data,
    // Memory write
    output logic wr_valid,
    output vss_wr_t wr,
    input wire logic wr_ready
);
    typedef enum logic [3:0] {
        S_IDLE, S_WIPE, S_INIT, S_LOAD_REQ, S_LOAD_WAIT, S_FF_REQ, S_FF_WAIT, S_FF_PUT,
        S_TB_PICK, S_TB_RUN, S_RTB_RUN, S_DUMP
    } vss_state_t;

    vss_state_t state;
    vss_cfg_t cfg_q;
    logic chain_ff;
    logic chain_tb;
    logic [COUNT_W-1:0] idx;
    logic [HIST_W-1:0] lp_cnt;
    logic [ADDR_W-1:0] ptr_assist;
    logic [ADDR_W-1:0] ptr_out;
    logic [WORD_W-1:0] delta_q;
    logic [METRIC_W-1:0] pm [NUM_STATES];
    logic [WORD_W-1:0] hist [HIST_WORDS];
    logic [NUM_STATES*METRIC_W-1:0] pm_flat;
    logic [HIST_WORDS*WORD_W-1:0] hist_flat;
    logic [SYMS_PER_WORD-1:0] decide;
    logic [WORD_W-1:0] delta;

    // Pick the metric extreme among all states
    function automatic logic [STATE_W-1:0] pick(input logic [NUM_STATES*METRIC_W-1:0] m, input logic want_max);
        logic [STATE_W-1:0] best;
        best = '0;
        for (int i = 1; i < NUM_STATES; i++) begin
            if (want_max ? (m[i*METRIC_W +: METRIC_W] > m[best*METRIC_W +: METRIC_W])
                         : (m[i*METRIC_W +: METRIC_W] < m[best*METRIC_W +: METRIC_W])) begin
                best = STATE_W'(i);
            end
        end
        return best;
    endfunction

    genvar g;
    generate
        for (g = 0; g < NUM_STATES; g++) begin : g_pm
            assign pm_flat[g*METRIC_W +: METRIC_W] = pm[g];
        end
        for (g = 0; g < HIST_WORDS; g++) begin : g_hist
            assign hist_flat[g*WORD_W +: WORD_W] = hist[g];
        end
        for (g = 0; g < SYMS_PER_WORD; g++) begin : g_lane
            wire logic [7:0] sym = rd_data[g*8 +: 8];
            assign decide[g] = cfg_q.equalize ? sym[7] : ^(sym & code_polynomials);
            assign delta[g*8 +: 8] = sym + autocorr_coeff_a + autocorr_coeff_b + autocorr_coeff_c;
        end
    endgenerate

    // Command and step decoding
    wire logic cmd_take = cmd_valid && state == S_IDLE && cmd < VSS_ABORT;
    wire logic abort_take = cmd_valid && state != S_IDLE && cmd == VSS_ABORT;
    wire logic [COUNT_W-1:0] blk_m1 = input_block_length - 1'b1;
    wire logic [HIST_W-1:0] last_word = blk_m1[HIST_W+5:6];
    wire logic [HIST_W-1:0] wi = idx[HIST_W-1:0];
    wire logic [COUNT_W-1:0] sym_next = idx + COUNT_W'(SYMS_PER_WORD);
    wire logic ff_last = sym_next >= session_symbol_count;
    wire logic learning = lp_cnt != '0;
    wire logic [HIST_WORDS*WORD_W+RTB_LONG-1:0] hist_ext = {{RTB_LONG{1'b0}}, hist_flat} >> idx;
    wire logic [RTB_LONG-1:0] rtb_mask = cfg_q.depth32 ? {RTB_LONG{1'b1}} : RTB_LONG'({RTB_SHORT{1'b1}});
    wire logic [RTB_LONG-1:0] rtb_word = {hist_ext[RTB_LONG-1:1], ~hist_ext[0]} & rtb_mask;
    wire logic push_valid = state == S_FF_PUT || (state == S_TB_RUN && !learning)
                            || state == S_RTB_RUN || state == S_DUMP;
    wire vss_wr_t push = (state == S_FF_PUT) ? vss_wr_t'{addr: ptr_assist, data: delta_q}
                       : (state == S_RTB_RUN) ? vss_wr_t'{addr: ptr_assist, data: WORD_W'(rtb_word)}
                       : vss_wr_t'{addr: ptr_out, data: hist[wi]};
    logic fifo_ready;
    wire logic fire = push_valid && fifo_ready;
    wire logic ff_step = (state == S_FF_WAIT && rd_data_valid && !cfg_q.equalize) || (state == S_FF_PUT && fire);
    wire logic ff_end = ff_step && ff_last;
    wire logic tb_end = state == S_TB_RUN && wi == '0 && (learning || fire);
    wire logic rtb_end = state == S_RTB_RUN && fire && idx == blk_m1;
    wire logic dump_end = state == S_DUMP && fire && wi == last_word;
    wire logic init_end = state == S_INIT && !chain_ff && idx[4:0] >= pm_init_count;
    wire logic load_end = state == S_LOAD_WAIT && rd_data_valid && idx[1:0] == 2'h3;
    wire vss_status_t ev = '{ff_done: ff_end, tb_done: tb_end || rtb_end, hd_done: dump_end,
                             pm_done: init_end || load_end, abort_done: abort_take};
    wire vss_status_t next_status = (status & ~status_clear) | ev;
    wire vss_state_t ff_after = chain_tb ? S_TB_PICK : (cfg_q.equalize && !cfg_q.recursive) ? S_DUMP : S_IDLE;
    wire vss_state_t tb_after = !cfg_q.equalize ? S_IDLE : cfg_q.recursive ? S_RTB_RUN : S_DUMP;

    // Status and interrupt lines; a new event wins over a clear
    always_ff @(posedge clk) begin
        if (reset) begin
            status <= '0;
            irq <= '0;
        end else begin
            status <= next_status; // see R24
            irq <= next_status & cfg_q.irq_en; // see R24
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state <= S_IDLE;
            cfg_q <= '0;
            chain_ff <= 1'b0;
            chain_tb <= 1'b0;
            idx <= '0;
            lp_cnt <= '0;
            busy <= 1'b0;
            tb_start_state <= '0;
            rd_req_valid <= 1'b0;
            rd_req_addr <= '0;
            ptr_assist <= '0;
            ptr_out <= '0;
            delta_q <= '0;
            pm <= '{default: METRIC_CLEAR};
            hist <= '{default: '0};
        end else if (abort_take) begin
            state <= S_IDLE; // see R15
            busy <= 1'b0;
            rd_req_valid <= 1'b0;
        end else begin
            case (state)
                S_IDLE: begin
                    if (cmd_take) begin // see R13, R14, R25
                        cfg_q <= cfg;
                        busy <= 1'b1;
                        idx <= '0;
                        ptr_assist <= assist_out_addr; // see R5
                        ptr_out <= tb_out_addr; // see R6
                        chain_ff <= cmd == VSS_WIPE_FF || cmd == VSS_WIPE_FF_TB; // see R22
                        chain_tb <= cmd == VSS_FF_TB || cmd == VSS_WIPE_FF_TB; // see R21, R23
                        rd_req_addr <= (cmd == VSS_METRIC_LOAD) ? metric_load_addr : input_start_addr;
                        case (cmd) // see R7
                            VSS_METRIC_WIPE, VSS_WIPE_FF, VSS_WIPE_FF_TB: state <= S_WIPE;
                            VSS_METRIC_LOAD: state <= S_LOAD_REQ; // see R1
                            VSS_FF, VSS_FF_TB: state <= S_FF_REQ;
                            VSS_TRACEBACK: state <= S_TB_PICK;
                            VSS_HIST_DUMP: state <= S_DUMP;
                            default: state <= S_IDLE;
                        endcase
                    end
                end
                S_WIPE: begin
                    pm[idx[STATE_W-1:0]] <= METRIC_CLEAR; // see R1
                    idx <= (idx[STATE_W-1:0] == STATE_W'(NUM_STATES-1)) ? '0 : idx + 1'b1;
                    if (idx[STATE_W-1:0] == STATE_W'(NUM_STATES-1)) begin
                        state <= S_INIT;
                    end
                end
                S_INIT: begin
                    if (chain_ff) begin // see R2
                        if (cfg_q.pm_init_upper) begin
                            pm[predefined_start_state][METRIC_W-1:METRIC_W/2] <= pm_init_value[METRIC_W-1:METRIC_W/2];
                        end else begin
                            pm[predefined_start_state][METRIC_W/2-1:0] <= pm_init_value[METRIC_W/2-1:0];
                        end
                        state <= S_FF_REQ; // see R22
                    end else if (init_end) begin
                        state <= S_IDLE;
                        busy <= 1'b0;
                    end else begin
                        pm[idx[STATE_W-1:0]] <= pm_init_value; // see R2
                        idx <= idx + 1'b1;
                    end
                end
                S_LOAD_REQ, S_FF_REQ: begin
                    if (!rd_req_valid) begin
                        rd_req_valid <= 1'b1;
                    end else if (rd_req_ready) begin
                        rd_req_valid <= 1'b0;
                        rd_req_addr <= rd_req_addr + ADDR_STEP;
                        state <= (state == S_LOAD_REQ) ? S_LOAD_WAIT : S_FF_WAIT;
                    end
                end
                S_LOAD_WAIT: begin
                    if (rd_data_valid) begin
                        for (int k = 0; k < METRICS_PER_WORD; k++) begin
                            pm[{idx[1:0], 2'(k)}] <= rd_data[k*METRIC_W +: METRIC_W]; // see R1
                        end
                        idx <= idx + 1'b1;
                        state <= load_end ? S_IDLE : S_LOAD_REQ;
                        busy <= !load_end;
                    end
                end
                S_FF_WAIT: begin
                    if (rd_data_valid) begin
                        hist[idx[HIST_W+5:6]][{idx[5:3], 3'h0} +: SYMS_PER_WORD] <= decide;
                        delta_q <= delta;
                        if (cfg_q.equalize) begin
                            state <= S_FF_PUT; // see R5
                        end else begin
                            idx <= sym_next;
                            state <= ff_last ? ff_after : S_FF_REQ; // see R16
                            busy <= !(ff_last && ff_after == S_IDLE);
                        end
                    end
                end
                S_FF_PUT: begin
                    if (fire) begin
                        ptr_assist <= ptr_assist + ADDR_STEP;
                        idx <= sym_next;
                        state <= ff_last ? ff_after : S_FF_REQ; // see R16, R17, R21
                        busy <= !(ff_last && ff_after == S_IDLE);
                    end
                end
                S_TB_PICK: begin
                    tb_start_state <= cfg_q.min_sel ? pick(pm_flat, 1'b0)
                                    : cfg_q.max_sel ? pick(pm_flat, 1'b1) : predefined_start_state; // see R10
                    lp_cnt <= learning_period;
                    idx <= COUNT_W'(last_word);
                    state <= S_TB_RUN;
                end
                S_TB_RUN: begin
                    if (learning) begin
                        lp_cnt <= lp_cnt - 1'b1; // see R11
                    end
                    if (fire) begin
                        ptr_out <= ptr_out + ADDR_STEP; // see R19
                    end
                    if (learning || fire) begin
                        idx <= idx - 1'b1;
                        if (tb_end) begin
                            state <= tb_after; // see R17
                            busy <= tb_after != S_IDLE;
                            idx <= '0;
                        end
                    end
                end
                S_RTB_RUN: begin
                    if (fire) begin // see R8, R9
                        ptr_assist <= ptr_assist + ADDR_STEP;
                        idx <= idx + 1'b1;
                        if (rtb_end) begin
                            state <= S_IDLE;
                            busy <= 1'b0;
                        end
                    end
                end
                S_DUMP: begin
                    if (fire) begin // see R17
                        ptr_out <= ptr_out + ADDR_STEP;
                        idx <= idx + 1'b1;
                        if (dump_end) begin
                            state <= S_IDLE;
                            busy <= 1'b0;
                        end
                    end
                end
                default: begin
                    state <= S_IDLE;
                    busy <= 1'b0;
                end
            endcase
        end
    end

    vss_fifo #(.WIDTH($bits(vss_wr_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .reset(reset),
        .in_valid(push_valid),
        .in_data(push),
        .in_ready(fifo_ready),
        .out_valid(wr_valid),
        .out_data(wr),
        .out_ready(wr_ready)
    );

    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    sequence wipe_last_s;
        state == S_WIPE && idx[STATE_W-1:0] == STATE_W'(NUM_STATES-1) && chain_ff;
    endsequence
    sequence into_ff_s;
        state == S_INIT ##1 state == S_FF_REQ;
    endsequence

    busy_ignore_a: assert property (cmd_valid && cmd != VSS_ABORT && state != S_IDLE |=> $stable(cfg_q)) // see R25
        else $error("command taken while busy");
    abort_idle_a: assert property (abort_take |=> state == S_IDLE && !busy && status.abort_done) // see R15
        else $error("abort did not return to idle");
    wipe_chain_a: assert property (wipe_last_s |=> into_ff_s) // see R22, R23
        else $error("wipe did not chain into feed-forward");
    ff_to_tb_a: assert property (ff_end && chain_tb |=> state == S_TB_PICK ##1 state == S_TB_RUN) // see R16, R21
        else $error("feed-forward did not chain into traceback");
    ff_start_a: assert property (cmd_take && cmd == VSS_FF |=> state == S_FF_REQ && busy) // see R14
        else $error("feed-forward not entered from idle");
    auto_init_a: assert property (state == S_INIT && chain_ff && !cfg_q.pm_init_upper
        |=> pm[$past(predefined_start_state)][METRIC_W/2-1:0] == $past(pm_init_value[METRIC_W/2-1:0])
            && pm[$past(predefined_start_state)][METRIC_W-1:METRIC_W/2] == METRIC_CLEAR[METRIC_W-1:METRIC_W/2]) // see R2
        else $error("auto init touched the wrong half");
    assist_addr_a: assert property (state == S_FF_PUT && fire |-> push.addr == ptr_assist) // see R5
        else $error("delta written off the assist address");
    tb_learn_a: assert property (state == S_TB_RUN && learning |-> !push_valid) // see R11
        else $error("decision emitted during learning period");
    rtb_branch_a: assert property (state == S_RTB_RUN && push_valid |-> push.data[0] == ~hist_ext[0]
        && push.data[WORD_W-1:RTB_LONG] == '0 && (cfg_q.depth32 || push.data[RTB_LONG-1:RTB_SHORT] == '0)) // see R8, R9
        else $error("recursive branch malformed");
    status_set_a: assert property (ev.ff_done |=> status.ff_done) // see R24
        else $error("completion not flagged");
endmodule
`default_nettype wire

// *** tb/vss_mem_model.sv ***
// Memory partner: answers reads with address-derived words, takes writes with random stalls
`timescale 1ns/1ps
`default_nettype none
module vss_mem_model import vss_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Read side
    input wire logic rd_req_valid,
    input wire logic [ADDR_W-1:0] rd_req_addr,
    output logic rd_req_ready,
    output logic rd_data_valid,
    output logic [WORD_W-1:0] rd_data,
    // Write side
    input wire logic wr_valid,
    input wire vss_wr_t wr,
    output logic wr_ready
);
    logic [ADDR_W-1:0] rd_addr_q[$];
    logic [ADDR_W-1:0] wr_addr_q[$];
    int pend;
    initial begin
        rd_req_ready = 1'b0;
        rd_data_valid = 1'b0;
        rd_data = 64'h0;
        wr_ready = 1'b0;
        pend = 0;
    end
    always @(posedge clk) begin
        rd_req_ready <= 1'b0;
        rd_data_valid <= 1'b0;
        rd_data <= ~rd_data;
        wr_ready <= !reset && ($urandom_range(3) != 0);
        if (reset) begin
            pend <= 0;
        end else begin
            if (rd_req_valid && rd_req_ready) begin
                rd_addr_q.push_back(rd_req_addr);
                pend <= 1 + $urandom_range(2);
            end else if (rd_req_valid && pend == 0) begin
                rd_req_ready <= ($urandom_range(1) == 1);
            end
            if (pend == 1) begin
                rd_data_valid <= 1'b1;
                rd_data <= {rd_addr_q[$], ~rd_addr_q[$]};
            end
            if (pend > 0) begin
                pend <= pend - 1;
            end
            if (wr_valid && wr_ready) begin
                wr_addr_q.push_back(wr.addr);
            end
        end
    end
endmodule
`default_nettype wire

// *** tb/viterbi_session_sequencer_test.sv ***
// Self-checking bench of the session sequencer with a memory partner
`timescale 1ns/1ps
`default_nettype none
module viterbi_session_sequencer_test;
    import vss_pkg::*;
    logic clk = 0, reset = 1, cmd_valid = 0, rd_req_ready, rd_data_valid, wr_ready, busy, rd_req_valid, wr_valid;
    vss_cmd_t cmd = VSS_FF;
    vss_cfg_t cfg = '0;
    logic [ADDR_W-1:0] in_addr = 0, as_addr = 0, tb_addr = 0, ml_addr = 0, rd_req_addr;
    logic [COUNT_W-1:0] blk = 64, cnt = 8;
    logic [7:0] ca = 0, cb = 0, cc = 0, poly = 0;
    logic [4:0] pm_cnt = 0;
    logic [METRIC_W-1:0] pm_val = 0;
    logic [STATE_W-1:0] pds = 0, tb_start_state;
    logic [HIST_W-1:0] learn = 0;
    logic [WORD_W-1:0] rd_data;
    vss_status_t status_clear = '0, status, irq;
    vss_wr_t wr;
    int fail_count = 0, n_compared = 0, cycles = 0;
    vss_sequencer u_vss_sequencer (.clk(clk), .reset(reset), .cmd_valid(cmd_valid), .cmd(cmd), .cfg(cfg),
        .input_start_addr(in_addr), .input_block_length(blk), .session_symbol_count(cnt),
        .autocorr_coeff_a(ca), .autocorr_coeff_b(cb), .autocorr_coeff_c(cc), .code_polynomials(poly),
        .assist_out_addr(as_addr), .tb_out_addr(tb_addr), .metric_load_addr(ml_addr), .pm_init_count(pm_cnt),
        .pm_init_value(pm_val), .predefined_start_state(pds), .learning_period(learn),
        .status_clear(status_clear), .status(status), .irq(irq), .busy(busy), .tb_start_state(tb_start_state),
        .rd_req_valid(rd_req_valid), .rd_req_addr(rd_req_addr), .rd_req_ready(rd_req_ready),
        .rd_data_valid(rd_data_valid), .rd_data(rd_data), .wr_valid(wr_valid), .wr(wr), .wr_ready(wr_ready));
    vss_mem_model u_vss_mem_model (.clk(clk), .reset(reset), .rd_req_valid(rd_req_valid),
        .rd_req_addr(rd_req_addr), .rd_req_ready(rd_req_ready), .rd_data_valid(rd_data_valid),
        .rd_data(rd_data), .wr_valid(wr_valid), .wr(wr), .wr_ready(wr_ready));
    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 80000) begin
            fail_count++;
            complete_run();
        end
    end
    task automatic complete_run;
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask
    task automatic issue(input vss_cmd_t c);
        @(negedge clk);
        cmd = c;
        cmd_valid = 1;
        @(negedge clk);
        cmd_valid = 0;
    endtask
    task automatic wait_idle;
        for (int i = 0; i < 20000 && (busy !== 1'b0 || wr_valid !== 1'b0); i++) @(negedge clk);
        check(busy, 0, "session did not end");
        @(negedge clk);
    endtask
    task automatic clear_all;
        @(negedge clk);
        status_clear = '1;
        @(negedge clk);
        status_clear = '0;
        u_vss_mem_model.rd_addr_q.delete();
        u_vss_mem_model.wr_addr_q.delete();
    endtask
    // Expected {ff_done, tb_done, hd_done} of one session
    function automatic logic [2:0] exp_done(vss_cmd_t c, logic eq, logic rec);
        logic ff, tb;
        ff = c inside {VSS_FF, VSS_FF_TB, VSS_WIPE_FF, VSS_WIPE_FF_TB};
        tb = c inside {VSS_FF_TB, VSS_WIPE_FF_TB, VSS_TRACEBACK};
        return {ff, tb, c == VSS_HIST_DUMP || ((ff || tb) && eq && !rec)};
    endfunction
    vss_cmd_t cl[8] = '{VSS_FF, VSS_FF_TB, VSS_WIPE_FF, VSS_WIPE_FF_TB, VSS_TRACEBACK, VSS_HIST_DUMP,
        VSS_METRIC_WIPE, VSS_METRIC_LOAD};
    initial begin
        void'($urandom(32'hb649b461));
        repeat (6) @(negedge clk);
        reset = 0;
        check(busy, 0, "busy after reset");
        for (int k = 0; k < 24; k++) begin
            vss_cmd_t c;
            c = cl[k % 8];
            cfg = '0;
            cfg.rate = 2'($urandom);
            cfg.equalize = 1'($urandom);
            cfg.recursive = 1'($urandom);
            cfg.depth32 = 1'($urandom);
            cfg.min_sel = (k % 3 == 1);
            cfg.max_sel = (k % 3 == 2);
            cfg.irq_en = 5'($urandom);
            in_addr = $urandom << 3;
            as_addr = $urandom << 3;
            tb_addr = $urandom << 3;
            ml_addr = $urandom << 3;
            cnt = 12'(8 + $urandom_range(56));
            blk = 12'(64 + $urandom_range(440));
            {ca, cb, cc, poly} = $urandom;
            {pm_cnt, pm_val} = 21'($urandom);
            pds = 4'($urandom);
            learn = 3'($urandom_range(1));
            issue(c);
            check(busy, 1, "busy not raised");
            wait_idle();
            check(exp_done(c, cfg.equalize, cfg.recursive), {status.ff_done, status.tb_done, status.hd_done},
                "done bits");
            check(irq, status & cfg.irq_en, "irq lines");
            if (c inside {VSS_METRIC_WIPE, VSS_METRIC_LOAD}) check(status.pm_done, 1, "metric done");
            if (c == VSS_METRIC_LOAD) begin
                check(u_vss_mem_model.rd_addr_q.size(), 4, "metric words");
                check(u_vss_mem_model.rd_addr_q[0], ml_addr, "metric base");
            end
            if (exp_done(c, 0, 0) >= 3'h4) begin
                check(u_vss_mem_model.rd_addr_q.size(), (cnt + 7) / 8, "symbol words");
                check(u_vss_mem_model.rd_addr_q[0], in_addr, "input base");
                if (cfg.equalize) check(u_vss_mem_model.wr_addr_q[0], as_addr, "assist base");
            end
            if (exp_done(c, 0, 0) == 3'h4) check(u_vss_mem_model.wr_addr_q.size() > 0, cfg.equalize, "writes");
            if (exp_done(c, 0, 0) & 3'h2 && !cfg.min_sel && !cfg.max_sel)
                check(tb_start_state, pds, "start state");
            else if (c == VSS_WIPE_FF_TB)
                check(tb_start_state, pm_val[7:0] == 0 ? 0 : cfg.max_sel ? pds : 4'(pds == 0), "extreme");
            clear_all();
        end
        issue(VSS_ABORT);
        check({busy, status.abort_done}, 0, "abort while idle");
        cfg = '0;
        cnt = 12'hfff;
        issue(VSS_FF);
        repeat (20) @(negedge clk);
        issue(VSS_HIST_DUMP);
        check(busy, 1, "busy during session");
        issue(VSS_ABORT);
        check(busy, 0, "abort ends session");
        check({status.abort_done, status.hd_done, status.ff_done}, 3'h4, "abort status");
        complete_run();
    end
endmodule
`default_nettype wire
